// ===== core/mlsr_pkg.sv
//------------------------------------------------------------------------------
// Purpose : Constants for the monitor limit status register slice
// Assumes : Conversion and limit compare logic runs on core_clk
// Notes   : Register offsets are byte-wide register pointer values
//------------------------------------------------------------------------------
package mlsr_pkg;

  //----------------------------------------------------------------------------
  // Widths and counts
  //----------------------------------------------------------------------------
  localparam int unsigned MLSR_DATA_W = 8;
  localparam int unsigned MLSR_ADDR_W = 8;
  localparam int unsigned MLSR_RAIL_N = 6;
  localparam int unsigned MLSR_AIN_N  = 8;
  localparam int unsigned MLSR_FLAG_N = 16;

  //----------------------------------------------------------------------------
  // Register offsets and reset values
  //----------------------------------------------------------------------------
  localparam logic [7:0] MLSR_OFS_INT_TEMP   = 8'h1f;
  localparam logic [7:0] MLSR_OFS_FLAGS_ONE  = 8'h20;
  localparam logic [7:0] MLSR_OFS_FLAGS_TWO  = 8'h21;
  localparam logic [7:0] MLSR_RST_BYTE       = 8'h00;

  //----------------------------------------------------------------------------
  // Field positions in the combined flag vector
  //----------------------------------------------------------------------------
  localparam int unsigned MLSR_BIT_RD1      = 0;
  localparam int unsigned MLSR_BIT_RD2      = 1;
  localparam int unsigned MLSR_BIT_RAIL_LSB = 2;
  localparam int unsigned MLSR_BIT_AIN_LSB  = 8;

endpackage : mlsr_pkg

// ===== core/mlsr_flag_if.sv
//------------------------------------------------------------------------------
// Purpose : Carries compare results and events into the flag bank
// Assumes : All signals on core_clk
// Notes   : done and evt are one-cycle pulses, oor is sampled with done
//------------------------------------------------------------------------------
`timescale 1ns/100ps
interface mlsr_flag_if #(
  parameter int unsigned WIDTH = 16
);
  logic [WIDTH-1:0] done;
  logic [WIDTH-1:0] oor;
  logic [WIDTH-1:0] evt;
  logic [WIDTH-1:0] flags;

  // Flag bank side
  modport bank (
    input  done,
    input  oor,
    input  evt,
    output flags
  );

  // Controlling side
  modport ctl (
    output done,
    output oor,
    output evt,
    input  flags
  );
endinterface : mlsr_flag_if

// ===== core/mlsr_flag_bank.sv
//------------------------------------------------------------------------------
// Purpose : Bank of out-of-limit status flags
// Assumes : Completion and event pulses last one cycle
// Notes   : An event in the completion cycle still sets the flag
//------------------------------------------------------------------------------
`timescale 1ns/100ps
module mlsr_flag_bank #(
  parameter int unsigned WIDTH = 16
) (
  // Clock and reset
  input  wire logic   core_clk,
  input  wire logic   rst_b,
  // Flag traffic
  mlsr_flag_if.bank   fl
);
  import mlsr_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } mlsr_bank_state_type;

  mlsr_bank_state_type st_q;
  mlsr_bank_state_type st_d;
  logic [WIDTH-1:0]    next_bit;

  //----------------------------------------------------------------------------
  // Next value of each flag
  //----------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_flag
      // Completion loads the fresh result, events always set
      assign next_bit[gi] = fl.done[gi] ? (fl.oor[gi] | fl.evt[gi])
                                        : (st_q.flags[gi] | fl.evt[gi]);
    end
  endgenerate

  // Next state
  always_comb
  begin
    st_d       = st_q;
    st_d.flags = next_bit;
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign fl.flags = st_q.flags;

  //----------------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------------
  a_flag_load_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
    ((fl.done & ~fl.oor & ~fl.evt) != '0)
      |=> ((fl.flags & $past(fl.done & ~fl.oor & ~fl.evt)) == '0))
    else $error("Flag not cleared by clean completion");

  a_flag_event_wins: assert property (@(posedge core_clk) disable iff (!rst_b)
    (fl.evt != '0) |=> ((fl.flags & $past(fl.evt)) == $past(fl.evt)))
    else $error("Event lost in flag bank");

  a_flag_hold_idle: assert property (@(posedge core_clk) disable iff (!rst_b)
    ((fl.done | fl.evt) == '0) |=> $stable(fl.flags))
    else $error("Flag moved without completion or event");

endmodule : mlsr_flag_bank

// ===== core/mlsr_status_regs.sv
//------------------------------------------------------------------------------
// Purpose : Internal temperature value and two limit status registers
// Assumes : Compare results arrive from logic on core_clk, no synchronisers
// Notes   : Registers are read through the serial bus register pointer port
//------------------------------------------------------------------------------
`timescale 1ns/100ps
module mlsr_status_regs (
  // Clock and reset
  input  wire logic                               core_clk,
  input  wire logic                               rst_b,
  // Register read port from the serial bus engine
  input  wire logic                               reg_rd_en,
  input  wire logic [mlsr_pkg::MLSR_ADDR_W-1:0]   reg_addr,
  output logic      [mlsr_pkg::MLSR_DATA_W-1:0]   reg_rd_data,
  output logic                                    reg_rd_ack,
  // Internal temperature conversion
  input  wire logic                               int_temp_done,
  input  wire logic [mlsr_pkg::MLSR_DATA_W-1:0]   int_temp_raw,
  input  wire logic [mlsr_pkg::MLSR_DATA_W-1:0]   int_temp_offset,
  output logic      [mlsr_pkg::MLSR_DATA_W-1:0]   int_temp_reading,
  // Remote diode compare results
  input  wire logic                               rd1_done,
  input  wire logic                               rd1_oor,
  input  wire logic                               rd2_done,
  input  wire logic                               rd2_oor,
  input  wire logic                               analog_input_nine_done,
  input  wire logic                               analog_input_nine_oor,
  input  wire logic                               analog_input_nine_volt_mode,
  // Overtemp mode levels per remote channel
  input  wire logic                               overtemp_mode_rd1,
  input  wire logic                               overtemp_mode_rd2,
  // Supply rail compare results
  input  wire logic [mlsr_pkg::MLSR_RAIL_N-1:0]   rail_done,
  input  wire logic [mlsr_pkg::MLSR_RAIL_N-1:0]   rail_oor,
  // General analog input compare results
  input  wire logic [mlsr_pkg::MLSR_AIN_N-1:0]    ain_done,
  input  wire logic [mlsr_pkg::MLSR_AIN_N-1:0]    ain_oor,
  // Interrupt masks and alert
  input  wire logic [mlsr_pkg::MLSR_DATA_W-1:0]   mask_one,
  input  wire logic [mlsr_pkg::MLSR_DATA_W-1:0]   mask_two,
  output logic                                    limit_alert
);
  import mlsr_pkg::*;

  //----------------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic [MLSR_DATA_W-1:0] int_temp;
    logic [MLSR_DATA_W-1:0] rd_data;
    logic                   rd_ack;
    logic                   alert;
    logic [1:0]             otm;
  } mlsr_state_type;

  mlsr_state_type         st_q;
  mlsr_state_type         st_d;
  logic [1:0]             otm_now;
  logic [1:0]             otm_edge;
  logic [MLSR_FLAG_N-1:0] flags;
  logic [MLSR_FLAG_N-1:0] mask_all;

  mlsr_flag_if #(.WIDTH(MLSR_FLAG_N)) fl ();

  // Byte fetch for a register pointer value
  function automatic logic [MLSR_DATA_W-1:0] mlsr_read_byte(
    input logic [MLSR_ADDR_W-1:0] addr,
    input logic [MLSR_DATA_W-1:0] temp,
    input logic [MLSR_FLAG_N-1:0] flg
  );
    logic [MLSR_DATA_W-1:0] val;
    val = MLSR_RST_BYTE;
    if (addr == MLSR_OFS_INT_TEMP)
      val = temp;
    else if (addr == MLSR_OFS_FLAGS_ONE)
      val = flg[MLSR_DATA_W-1:0];
    else if (addr == MLSR_OFS_FLAGS_TWO)
      val = flg[MLSR_FLAG_N-1:MLSR_DATA_W];
    return val;
  endfunction : mlsr_read_byte

  //----------------------------------------------------------------------------
  // Overtemp mode edges
  //----------------------------------------------------------------------------
  // Both engage and release give one pulse each
  assign otm_now  = {overtemp_mode_rd2, overtemp_mode_rd1};
  assign otm_edge = otm_now ^ st_q.otm;

  //----------------------------------------------------------------------------
  // Flag bank feed
  //----------------------------------------------------------------------------
  // Bit 1 follows input nine when that pin pair measures voltage
  always_comb
  begin
    fl.done                    = '0;
    fl.oor                     = '0;
    fl.evt                     = '0;
    fl.done[MLSR_BIT_RD1]      = rd1_done;
    fl.oor[MLSR_BIT_RD1]       = rd1_oor;
    fl.evt[MLSR_BIT_RD1]       = otm_edge[0];
    fl.done[MLSR_BIT_RD2]      = analog_input_nine_volt_mode ? analog_input_nine_done : rd2_done;
    fl.oor[MLSR_BIT_RD2]       = analog_input_nine_volt_mode ? analog_input_nine_oor  : rd2_oor;
    fl.evt[MLSR_BIT_RD2]       = otm_edge[1];
    fl.done[MLSR_BIT_RAIL_LSB +: MLSR_RAIL_N] = rail_done;
    fl.oor[MLSR_BIT_RAIL_LSB +: MLSR_RAIL_N]  = rail_oor;
    fl.done[MLSR_BIT_AIN_LSB +: MLSR_AIN_N]   = ain_done;
    fl.oor[MLSR_BIT_AIN_LSB +: MLSR_AIN_N]    = ain_oor;
  end

  assign flags    = fl.flags;
  assign mask_all = {mask_two, mask_one};

  // Status flag storage
  mlsr_flag_bank #(
    .WIDTH    (MLSR_FLAG_N)
  ) u_flag_bank (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .fl       (fl.bank)
  );

  //----------------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------------
  always_comb
  begin
    st_d        = st_q;
    st_d.otm    = otm_now;
    st_d.rd_ack = reg_rd_en;
    // Offset applied in two's complement, wrapping at eight bits
    if (int_temp_done)
      st_d.int_temp = MLSR_DATA_W'(int_temp_raw + int_temp_offset);
    // Read data captured at the request, zero for unmapped pointers
    if (reg_rd_en)
      st_d.rd_data = mlsr_read_byte(reg_addr, st_q.int_temp, flags);
    // Masks gate only the alert, flags stay visible
    st_d.alert = |(flags & ~mask_all);
  end

  //----------------------------------------------------------------------------
  // State register
  //----------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  //----------------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------------
  assign reg_rd_data      = st_q.rd_data;
  assign reg_rd_ack       = st_q.rd_ack;
  assign int_temp_reading = st_q.int_temp;
  assign limit_alert      = st_q.alert;

  //----------------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  a_temp_offset_store: assert property (
    int_temp_done |=> int_temp_reading == $past(MLSR_DATA_W'(int_temp_raw + int_temp_offset)))
    else $error("Internal temperature not stored with offset");

  a_temp_hold: assert property (
    !int_temp_done |=> $stable(int_temp_reading))
    else $error("Internal temperature changed without conversion");

  a_temp_read_back: assert property (
    reg_rd_en && reg_addr == MLSR_OFS_INT_TEMP
      |=> reg_rd_ack && reg_rd_data == $past(int_temp_reading))
    else $error("Internal temperature read mismatch");

  // Overtemp mode edges and per-channel loads
  a_rd1_engage_set: assert property (
    $rose(overtemp_mode_rd1) |=> flags[MLSR_BIT_RD1])
    else $error("Engage did not set remote one flag");

  a_rd1_release_set: assert property (
    $fell(overtemp_mode_rd1) |=> flags[MLSR_BIT_RD1])
    else $error("Release did not set remote one flag");

  a_rd2_engage_set: assert property (
    $rose(overtemp_mode_rd2) |=> flags[MLSR_BIT_RD2])
    else $error("Engage did not set remote two flag");

  a_rd2_release_set: assert property (
    $fell(overtemp_mode_rd2) |=> flags[MLSR_BIT_RD2])
    else $error("Release did not set remote two flag");

  a_otm_single_set: assert property (
    $past(rst_b) && overtemp_mode_rd1 && $stable(overtemp_mode_rd1) && rd1_done && !rd1_oor
      |=> !flags[MLSR_BIT_RD1])
    else $error("Overtemp level kept setting the flag");

  a_rd2_single_set: assert property (
    $past(rst_b) && overtemp_mode_rd2 && $stable(overtemp_mode_rd2) && !analog_input_nine_volt_mode
      && rd2_done && !rd2_oor |=> !flags[MLSR_BIT_RD2])
    else $error("Overtemp level kept setting remote two flag");

  a_rd1_result: assert property (
    $past(rst_b) && $stable(overtemp_mode_rd1) && rd1_done
      |=> flags[MLSR_BIT_RD1] == $past(rd1_oor))
    else $error("Remote one flag not loaded from compare");

  a_rd2_result: assert property (
    $past(rst_b) && $stable(overtemp_mode_rd2) && !analog_input_nine_volt_mode && rd2_done
      |=> flags[MLSR_BIT_RD2] == $past(rd2_oor))
    else $error("Remote two flag not loaded from compare");

  a_analog_input_nine_clear: assert property (
    $past(rst_b) && $stable(overtemp_mode_rd2) && analog_input_nine_volt_mode && analog_input_nine_done && !analog_input_nine_oor
      |=> !flags[MLSR_BIT_RD2])
    else $error("Input nine clean result did not clear bit one");

  a_analog_input_nine_select: assert property (
    analog_input_nine_volt_mode && analog_input_nine_done && analog_input_nine_oor |=> flags[MLSR_BIT_RD2])
    else $error("Input nine result not routed to bit one");

  a_rail_clear: assert property (
    rail_done[0] && rail_done[5]
      |=> flags[MLSR_BIT_RAIL_LSB] == $past(rail_oor[0])
          && flags[MLSR_BIT_RAIL_LSB + 5] == $past(rail_oor[5]))
    else $error("Rail flag mismatch");

  // Every rail flag loads its own compare result
  genvar ri;
  generate
    for (ri = 0; ri < MLSR_RAIL_N; ri++)
    begin : g_rail_chk
      a_rail_result: assert property (
        rail_done[ri] |=> flags[MLSR_BIT_RAIL_LSB + ri] == $past(rail_oor[ri]))
        else $error("Rail flag not loaded from compare");
    end
  endgenerate

  a_ain_set: assert property (
    ain_done[3] && ain_oor[3] |=> flags[MLSR_BIT_AIN_LSB + 3] ##1
      (!$past(ain_done[3]) || flags[MLSR_BIT_AIN_LSB + 3] == $past(ain_oor[3])))
    else $error("Analog input flag not set");

  // Every analog input flag loads its own compare result
  genvar ai;
  generate
    for (ai = 0; ai < MLSR_AIN_N; ai++)
    begin : g_ain_chk
      a_ain_result: assert property (
        ain_done[ai] |=> flags[MLSR_BIT_AIN_LSB + ai] == $past(ain_oor[ai]))
        else $error("Analog input flag not loaded from compare");
    end
  endgenerate

  a_status_read: assert property (
    reg_rd_en && reg_addr == MLSR_OFS_FLAGS_ONE
      |=> reg_rd_data == $past(flags[MLSR_DATA_W-1:0]))
    else $error("Status one read mismatch");

  // Read port answers
  a_flags_two_read: assert property (
    reg_rd_en && reg_addr == MLSR_OFS_FLAGS_TWO
      |=> reg_rd_data == $past(flags[MLSR_FLAG_N-1:MLSR_DATA_W]))
    else $error("Status two read mismatch");

  a_ack_pulse: assert property (
    1'b1 |=> reg_rd_ack == $past(reg_rd_en))
    else $error("Read acknowledge not one cycle after request");

  a_data_hold: assert property (
    !reg_rd_en |=> $stable(reg_rd_data))
    else $error("Read data moved without a request");

  a_unmapped_zero: assert property (
    reg_rd_en && reg_addr != MLSR_OFS_INT_TEMP && reg_addr != MLSR_OFS_FLAGS_ONE
      && reg_addr != MLSR_OFS_FLAGS_TWO |=> reg_rd_data == MLSR_RST_BYTE)
    else $error("Unmapped read not zero");

  a_mask_alert: assert property (
    1'b1 |=> limit_alert == $past(|(flags & ~mask_all)))
    else $error("Alert does not follow masked flags");

  a_mask_keeps_flag: assert property (
    mask_one[0] && rd1_done && rd1_oor |=> flags[MLSR_BIT_RD1] && !limit_alert
      || flags[MLSR_BIT_RD1])
    else $error("Mask suppressed the status flag");

  a_mask_two_keeps: assert property (
    mask_two[7] && ain_done[7] && ain_oor[7] |=> flags[MLSR_BIT_AIN_LSB + 7])
    else $error("Mask suppressed an analog input flag");

  c_rd1_engage: cover property ($rose(overtemp_mode_rd1) ##1 flags[MLSR_BIT_RD1]);
  c_read_flags: cover property (reg_rd_en && reg_addr == MLSR_OFS_FLAGS_ONE
                                && flags[MLSR_DATA_W-1:0] != '0);
  c_alert_up:   cover property ($rose(limit_alert));
  c_analog_input_nine_mode:  cover property (analog_input_nine_volt_mode && analog_input_nine_done && analog_input_nine_oor);
  c_rd2_release: cover property ($fell(overtemp_mode_rd2) ##1 flags[MLSR_BIT_RD2]);

endmodule : mlsr_status_regs

// ===== testbench/mlsr_host_model.sv
//----------------------------------------
// Purpose : Serial bus engine stand-in issuing pointer reads
// Assumes : One read in flight at a time
// Notes   : Idle address flips between the last one and its inverse every cycle
//----------------------------------------
`timescale 1ns/100ps
module mlsr_host_model (
  // Clock and reset
  input  wire logic                             core_clk,
  input  wire logic                             rst_b,
  // Bench requests
  input  wire logic                             req,
  input  wire logic [mlsr_pkg::MLSR_ADDR_W-1:0] req_addr,
  output logic                                  rsp_valid,
  output logic      [mlsr_pkg::MLSR_DATA_W-1:0] rsp_data,
  // Register read port
  output logic                                  reg_rd_en,
  output logic      [mlsr_pkg::MLSR_ADDR_W-1:0] reg_addr,
  input  wire logic [mlsr_pkg::MLSR_DATA_W-1:0] reg_rd_data,
  input  wire logic                             reg_rd_ack
);
  // One-cycle strobe per read, no write path at all
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rd_en <= 1'b0;
      reg_addr  <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
    end
    else
    begin
      reg_rd_en <= req;
      reg_addr  <= req ? req_addr : ~reg_addr;
      rsp_valid <= reg_rd_ack;
      rsp_data  <= reg_rd_ack ? reg_rd_data : rsp_data;
    end
  end
endmodule : mlsr_host_model

// ===== testbench/monitor_limit_status_regs_test.sv
//----------------------------------------
// Purpose : Self-checking bench for the limit status registers
// Assumes : Compare results driven as same-clock pulses
// Notes   : Reads go through the host model
//----------------------------------------
`timescale 1ns/100ps
module monitor_limit_status_regs_test;
  import mlsr_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       req = 1'b0;
  logic [7:0] req_addr = 8'h00;
  logic       rsp_valid, reg_rd_en, reg_rd_ack, limit_alert;
  logic [7:0] rsp_data, reg_addr, reg_rd_data, int_temp_reading;
  logic       int_temp_done = 1'b0, analog_input_nine_volt_mode = 1'b0;
  logic [7:0] int_temp_raw = 8'h00, int_temp_offset = 8'h00;
  logic       rd1_done = 1'b0, rd1_oor = 1'b0, rd2_done = 1'b0, rd2_oor = 1'b0;
  logic       analog_input_nine_done = 1'b0, analog_input_nine_oor = 1'b0;
  logic       overtemp_mode_rd1 = 1'b0, overtemp_mode_rd2 = 1'b0;
  logic [5:0] rail_done = 6'h00, rail_oor = 6'h00;
  logic [7:0] ain_done = 8'h00, ain_oor = 8'h00, mask_one = 8'h00, mask_two = 8'h00;
  int         fail_count = 0;
  int         n_compared = 0;

  // Clock of 5 ns
  always #2.5 core_clk = ~core_clk;

  // Far side and block
  mlsr_host_model host (.core_clk, .rst_b, .req, .req_addr, .rsp_valid, .rsp_data,
    .reg_rd_en, .reg_addr, .reg_rd_data, .reg_rd_ack);
  mlsr_status_regs dut (.core_clk, .rst_b, .reg_rd_en, .reg_addr, .reg_rd_data,
    .reg_rd_ack, .int_temp_done, .int_temp_raw, .int_temp_offset, .int_temp_reading,
    .rd1_done, .rd1_oor, .rd2_done, .rd2_oor, .analog_input_nine_done, .analog_input_nine_oor, .analog_input_nine_volt_mode,
    .overtemp_mode_rd1, .overtemp_mode_rd2, .rail_done, .rail_oor, .ain_done,
    .ain_oor, .mask_one, .mask_two, .limit_alert);

  //----------------------------------------
  // Helpers
  //----------------------------------------
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  // Pointer read through the host, then compare the byte
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    int n;
    @(posedge core_clk);
    req      <= 1'b1;
    req_addr <= a;
    @(posedge core_clk);
    req <= 1'b0;
    n = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    while (rsp_valid !== 1'b1 && n < 20);
    chk8({what, " response"}, 8'h01, {7'h00, rsp_valid});
    chk8(what, exp, rsp_data);
  endtask : rd

  // One completed conversion on every channel; oor flips afterwards
  task automatic conv(input logic o1, o2, o9, input logic [5:0] r, input logic [7:0] a);
    @(posedge core_clk);
    {rd1_done, rd2_done, analog_input_nine_done, rail_done, ain_done} <= '1;
    {rd1_oor, rd2_oor, analog_input_nine_oor, rail_oor, ain_oor} <= {o1, o2, o9, r, a};
    @(posedge core_clk);
    {rd1_done, rd2_done, analog_input_nine_done, rail_done, ain_done} <= '0;
    {rd1_oor, rd2_oor, analog_input_nine_oor, rail_oor, ain_oor} <= ~{o1, o2, o9, r, a};
  endtask : conv

  task automatic ot(input int ch, input logic v);
    @(posedge core_clk);
    if (ch == 0)
      overtemp_mode_rd1 <= v;
    else
      overtemp_mode_rd2 <= v;
  endtask : ot

  //----------------------------------------
  // Scenarios
  //----------------------------------------
  // Reset pulse, then every register and an unmapped pointer read zero
  task automatic t_reset();
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(MLSR_OFS_INT_TEMP, MLSR_RST_BYTE, "internal_temp_reading");
    rd(MLSR_OFS_FLAGS_ONE, MLSR_RST_BYTE, "temp_and_rail_limit_flags");
    rd(MLSR_OFS_FLAGS_TWO, MLSR_RST_BYTE, "analog_input_limit_flags");
    rd(8'h22, 8'h00, "unmapped pointer");
  endtask : t_reset

  // Stored value is raw plus signed offset, held after raw moves on
  task automatic t_temp(input logic [7:0] raw, input logic [7:0] ofs);
    @(posedge core_clk);
    int_temp_raw    <= raw;
    int_temp_offset <= ofs;
    int_temp_done   <= 1'b1;
    @(posedge core_clk);
    int_temp_done <= 1'b0;
    int_temp_raw  <= ~raw;
    rd(MLSR_OFS_INT_TEMP, raw + ofs, "internal_temp_reading");
    chk8("int_temp_reading port", raw + ofs, int_temp_reading);
  endtask : t_temp

  // Bit placement of both status registers and the input nine select
  task automatic t_flags();
    conv(1'b1, 1'b0, 1'b1, 6'b101001, 8'h3c);
    rd(MLSR_OFS_FLAGS_ONE, 8'ha5, "flags one");
    rd(MLSR_OFS_FLAGS_TWO, 8'h3c, "flags two");
    conv(1'b0, 1'b1, 1'b0, 6'b010110, 8'hc3);
    rd(MLSR_OFS_FLAGS_ONE, 8'h5a, "flags one");
    rd(MLSR_OFS_FLAGS_TWO, 8'hc3, "flags two");
    @(posedge core_clk);
    analog_input_nine_volt_mode <= 1'b1;
    conv(1'b0, 1'b0, 1'b1, 6'h00, 8'h00);
    rd(MLSR_OFS_FLAGS_ONE, 8'h02, "input nine flag");
    conv(1'b0, 1'b1, 1'b0, 6'h00, 8'h00);
    rd(MLSR_OFS_FLAGS_ONE, 8'h00, "input nine flag");
    @(posedge core_clk);
    analog_input_nine_volt_mode <= 1'b0;
  endtask : t_flags

  // Each mode edge sets the bit once; a held level does not
  task automatic t_overtemp(input int ch);
    logic [7:0] bit_mask;
    bit_mask = 8'h01 << ch;
    ot(ch, 1'b1);
    rd(MLSR_OFS_FLAGS_ONE, bit_mask, "overtemp engage");
    conv(1'b0, 1'b0, 1'b0, 6'h00, 8'h00);
    rd(MLSR_OFS_FLAGS_ONE, 8'h00, "overtemp held");
    ot(ch, 1'b0);
    rd(MLSR_OFS_FLAGS_ONE, bit_mask, "overtemp disengage");
    conv(1'b0, 1'b0, 1'b0, 6'h00, 8'h00);
  endtask : t_overtemp

  // Masks gate the alert only, never the flag
  task automatic t_alert();
    mask_two <= 8'hff;
    conv(1'b1, 1'b0, 1'b0, 6'h00, 8'h80);
    repeat (3) @(posedge core_clk);
    #1;
    chk8("limit_alert", 8'h01, {7'h00, limit_alert});
    @(posedge core_clk);
    mask_one <= 8'h01;
    conv(1'b1, 1'b0, 1'b0, 6'h00, 8'h80);
    repeat (3) @(posedge core_clk);
    #1;
    chk8("limit_alert", 8'h00, {7'h00, limit_alert});
    rd(MLSR_OFS_FLAGS_ONE, 8'h01, "masked flag");
    rd(MLSR_OFS_FLAGS_TWO, 8'h80, "masked input flag");
    @(posedge core_clk);
    mask_two <= 8'h00;
    repeat (3) @(posedge core_clk);
    #1;
    chk8("limit_alert", 8'h01, {7'h00, limit_alert});
  endtask : t_alert

  task automatic conclude();
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  // Main sequence
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset();
    t_temp(8'h30, 8'hfb);
    t_temp(8'hff, 8'h02);
    t_flags();
    t_overtemp(0);
    t_overtemp(1);
    t_alert();
    t_reset();
    conclude();
  end

  // Watchdog
  initial
  begin
    #20000;
    fail_count++;
    conclude();
  end
endmodule : monitor_limit_status_regs_test
